// ### hdl/pmbus_seq_consts.svh
// constants for the pmbus sequencing, status and telemetry register bank
`ifndef PMBUS_SEQ_CONSTS_SVH
`define PMBUS_SEQ_CONSTS_SVH
// command codes
`define CMD_PAGE 8'h00
`define CMD_VIN_OV_LIMIT 8'h55
`define CMD_VIN_OV_ACTION 8'h56
`define CMD_VIN_UV_WARN 8'h58
`define CMD_TURN_ON_DELAY_TIME 8'h60
`define CMD_TURN_ON_RISE_TIME 8'h61
`define CMD_TON_LIMIT 8'h62
`define CMD_TON_ACTION 8'h63
`define CMD_TURN_OFF_DELAY_TIME 8'h64
`define CMD_TURN_OFF_FALL_TIME 8'h65
`define CMD_STAT_BYTE 8'h78
`define CMD_STAT_WORD 8'h79
`define CMD_STAT_VOUT 8'h7A
`define CMD_STAT_IOUT 8'h7B
`define CMD_STAT_INPUT 8'h7C
`define CMD_STAT_TEMP 8'h7D
`define CMD_STAT_CML 8'h7E
`define CMD_STAT_DEV 8'h80
`define CMD_MEAS_VIN 8'h88
`define CMD_MEAS_VOUT 8'h8B
`define CMD_MEAS_IOUT 8'h8C
`define CMD_MEAS_TEXT 8'h8D
`define CMD_MEAS_TINT 8'h8E
`define CMD_MEAS_FREQ 8'h95
`define CMD_REVISION 8'h98
`define CMD_MAKER_ID 8'h99
`define CMD_MODEL_ID 8'hAD
// reset values and protocol revision
`define RST_VIN_OV_LIMIT 16'hD3E0
`define RST_VIN_OV_ACTION 8'h80
`define RST_VIN_UV_WARN 16'hCB26
`define RST_TURN_ON_DELAY_TIME 16'h8000
`define RST_TURN_ON_RISE_TIME 16'hD200
`define RST_TON_LIMIT 16'hD280
`define RST_TON_ACTION 8'hB8
`define RST_TURN_OFF_DELAY_TIME 16'h8000
`define RST_TURN_OFF_FALL_TIME 16'hD200
`define RST_PAGE 8'h00
`define PROTOCOL_REVISION 8'h22
// status field positions
`define SB_OFF 6
`define SB_TEMP 2
`define SB_CML 1
`define SW_VOUT 15
`define SW_IOUT 14
`define SW_INPUT 13
`define SW_DEV 12
`define VOUT_TON_MAX 2
`define CML_BAD_CMD 7
`define CML_BAD_DATA 6
// timing: sequencer time base is one sixteenth of a millisecond
`define CLK_PERIOD_NS 50
`define SEQ_TICK_NS 62500
`define SEQ_TICK_CYC (`SEQ_TICK_NS / `CLK_PERIOD_NS)
`endif

// ### hdl/pmbus_seq_pkg.sv
// types shared by the pmbus sequencing register bank
package pmbus_seq_pkg;
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [3:0] index;
        logic [15:0] wdata;
    } cmd_req_type;
    typedef struct packed {
        logic [15:0] vout;
        logic [15:0] iout;
        logic [15:0] text;
        logic [15:0] freq;
    } chan_meas_type;
    typedef struct packed {
        logic [7:0] vout;
        logic [7:0] iout;
        logic [7:0] temp;
        logic [7:0] dev;
    } chan_evt_type;
    typedef enum logic [2:0] {
        SEQ_OFF = 3'b000,
        SEQ_ON_DELAY = 3'b001,
        SEQ_RISING = 3'b010,
        SEQ_ON = 3'b011,
        SEQ_OFF_DELAY = 3'b100,
        SEQ_FALLING = 3'b101
    } seq_state_type;
endpackage

// ### hdl/pmbus_seq_status_telemetry_regs.sv
// pmbus command register bank with turn-on/turn-off sequencer, status and telemetry
`timescale 1ns/1ns
`include "pmbus_seq_consts.svh"
module pmbus_seq_status_telemetry_regs
    import pmbus_seq_pkg::*;
#(
    parameter logic [23:0] MAKER_STRING = 24'h4142_43, // arbitrary value
    parameter logic [71:0] MODEL_STRING = 72'h41_4243_4431_3233_3435, // arbitrary value
    parameter int TICK_CYCLES = `SEQ_TICK_CYC
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // command port
    input wire cmd_req_type cmd_i,
    output logic rsp_valid_o,
    output logic [15:0] rsp_data_o,
    // on/off requests and power-good per channel
    input wire logic run_pin_i,
    input wire logic [1:0] operation_on_i,
    input wire logic [1:0] vout_above_uv_i,
    // measurements and fault events
    input wire logic [15:0] meas_vin_i,
    input wire logic [15:0] meas_tint_i,
    input wire chan_meas_type [1:0] meas_i,
    input wire logic [7:0] input_evt_i,
    input wire chan_evt_type [1:0] evt_i,
    // sequencer outputs
    output logic [1:0] power_on_o,
    output logic [1:0] ramp_up_o,
    output logic [1:0] ramp_down_o,
    output logic [1:0] ton_timeout_o,
    // configuration for the analogue side
    output logic [15:0] vin_ov_limit_o,
    output logic [15:0] vin_uv_warn_o,
    output logic [15:0] vin_ov_action_o
);

    // l11 time in ms converted to sixteenths of a ms; negative reads as zero
    function automatic logic [31:0] l11_to_ticks(input logic [15:0] w);
        logic signed [5:0] sh;
        logic [31:0] m;
        sh = 6'(signed'(w[15:11])) + 6'sd4;
        m = {21'h00_0000, w[10:0]};
        if (w[10]) begin
            l11_to_ticks = 32'h0000_0000;
        end else if (sh >= 0) begin
            l11_to_ticks = m << sh;
        end else begin
            l11_to_ticks = m >> (-sh);
        end
    endfunction

    // registers and state
    logic [7:0] page_r, page_nxt;
    logic [15:0] vin_ov_limit_r, vin_ov_limit_nxt;
    logic [15:0] vin_uv_warn_r, vin_uv_warn_nxt;
    logic [7:0] vin_ov_action_r [2], vin_ov_action_nxt [2];
    logic [15:0] turn_on_delay_time_r [2], turn_on_delay_time_nxt [2];
    logic [15:0] turn_on_rise_time_r [2], turn_on_rise_time_nxt [2];
    logic [15:0] ton_limit_r [2], ton_limit_nxt [2];
    logic [7:0] ton_action_r [2], ton_action_nxt [2];
    logic [15:0] turn_off_delay_time_r [2], turn_off_delay_time_nxt [2];
    logic [15:0] turn_off_fall_time_r [2], turn_off_fall_time_nxt [2];
    logic [7:0] st_vout_r [2], st_vout_nxt [2];
    logic [7:0] st_iout_r [2], st_iout_nxt [2];
    logic [7:0] st_temp_r [2], st_temp_nxt [2];
    logic [7:0] st_dev_r [2], st_dev_nxt [2];
    logic [7:0] st_input_r, st_input_nxt;
    logic [7:0] st_cml_r, st_cml_nxt;
    logic rsp_valid_r, rsp_valid_nxt;
    logic [15:0] rsp_data_r, rsp_data_nxt;
    logic run_meta_r, run_sync_r;
    logic [10:0] pre_r, pre_nxt;
    logic tick_r, tick_nxt;
    seq_state_type seq_r [2], seq_nxt [2];
    logic [31:0] cnt_r [2], cnt_nxt [2];
    logic [31:0] tocnt_r [2], tocnt_nxt [2];
    logic proven_r [2], proven_nxt [2];
    logic [1:0] pwr_r, pwr_nxt, up_r, up_nxt, dn_r, dn_nxt, tmo_r, tmo_nxt;
    logic ch;
    logic [7:0] sbyte [2];
    logic [15:0] sword [2];
    logic [1:0] timeout_evt;

    assign ch = page_r[0];

    // enable pin enters through two flip-flops
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            run_meta_r <= 1'b0;
            run_sync_r <= 1'b0;
        end else begin
            run_meta_r <= run_pin_i;
            run_sync_r <= run_meta_r;
        end
    end

    // status summaries built from the detail bytes and sequencer state
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            sbyte[c] = 8'h00;
            sbyte[c][`SB_OFF] = ~pwr_r[c];
            sbyte[c][`SB_TEMP] = |st_temp_r[c];
            sbyte[c][`SB_CML] = |st_cml_r;
            sword[c] = {8'h00, sbyte[c]};
            sword[c][`SW_VOUT] = |st_vout_r[c];
            sword[c][`SW_IOUT] = |st_iout_r[c];
            sword[c][`SW_INPUT] = |st_input_r;
            sword[c][`SW_DEV] = |st_dev_r[c];
        end
    end

    // sequencer time base prescaler
    always_comb begin
        tick_nxt = 1'b0;
        pre_nxt = pre_r + 11'h001;
        if (pre_r == 11'(TICK_CYCLES - 1)) begin
            pre_nxt = 11'h000;
            tick_nxt = 1'b1;
        end
    end

    // per-channel turn-on/turn-off sequencer
    always_comb begin
        logic req_on;
        logic adv;
        req_on = 1'b0;
        adv = 1'b0;
        timeout_evt = 2'b00;
        for (int c = 0; c < 2; c++) begin
            req_on = run_sync_r & operation_on_i[c];
            seq_nxt[c] = seq_r[c];
            cnt_nxt[c] = tick_r ? cnt_r[c] + 32'h0000_0001 : cnt_r[c];
            tocnt_nxt[c] = tick_r ? tocnt_r[c] + 32'h0000_0001 : tocnt_r[c];
            proven_nxt[c] = proven_r[c] | vout_above_uv_i[c];
            adv = 1'b0;
            case (seq_r[c])
                SEQ_OFF: begin
                    proven_nxt[c] = 1'b0;
                    if (req_on) begin
                        seq_nxt[c] = SEQ_ON_DELAY;
                        adv = 1'b1;
                    end
                end
                SEQ_ON_DELAY: begin
                    if (!req_on) begin
                        seq_nxt[c] = SEQ_OFF;
                        adv = 1'b1;
                    end else if (cnt_r[c] >= l11_to_ticks(turn_on_delay_time_r[c])) begin
                        seq_nxt[c] = SEQ_RISING;
                        adv = 1'b1;
                        tocnt_nxt[c] = 32'h0000_0000;
                        proven_nxt[c] = vout_above_uv_i[c];
                    end
                end
                SEQ_RISING, SEQ_ON: begin
                    if (seq_r[c] == SEQ_RISING && cnt_r[c] >= l11_to_ticks(turn_on_rise_time_r[c])) begin
                        seq_nxt[c] = SEQ_ON;
                        adv = 1'b1;
                    end
                    if (!proven_r[c] && ton_limit_r[c][10:0] != 11'h000
                        && tocnt_r[c] >= l11_to_ticks(ton_limit_r[c])) begin
                        timeout_evt[c] = 1'b1;
                        proven_nxt[c] = 1'b1;
                        if (ton_action_r[c][7:6] != 2'b00) begin
                            seq_nxt[c] = SEQ_OFF;
                            adv = 1'b1;
                        end
                    end
                    if (!req_on && seq_nxt[c] != SEQ_OFF) begin
                        seq_nxt[c] = SEQ_OFF_DELAY;
                        adv = 1'b1;
                    end
                end
                SEQ_OFF_DELAY: begin
                    if (cnt_r[c] >= l11_to_ticks(turn_off_delay_time_r[c])) begin
                        seq_nxt[c] = SEQ_FALLING;
                        adv = 1'b1;
                    end
                end
                SEQ_FALLING: begin
                    if (cnt_r[c] >= l11_to_ticks(turn_off_fall_time_r[c])) begin
                        seq_nxt[c] = SEQ_OFF;
                        adv = 1'b1;
                    end
                end
                default: begin
                    seq_nxt[c] = SEQ_OFF;
                    adv = 1'b1;
                end
            endcase
            if (adv) begin
                cnt_nxt[c] = 32'h0000_0000;
            end
            pwr_nxt[c] = seq_nxt[c] != SEQ_OFF && seq_nxt[c] != SEQ_ON_DELAY;
            up_nxt[c] = seq_nxt[c] == SEQ_RISING;
            dn_nxt[c] = seq_nxt[c] == SEQ_FALLING;
            tmo_nxt[c] = timeout_evt[c];
        end
    end

    // command decode: writes, reads, status set and clear
    always_comb begin
        logic wr;
        logic bad_cmd;
        logic bad_data;
        logic [7:0] clr;
        wr = cmd_i.valid & cmd_i.write;
        bad_cmd = 1'b0;
        bad_data = 1'b0;
        clr = cmd_i.wdata[7:0];
        page_nxt = page_r;
        vin_ov_limit_nxt = vin_ov_limit_r;
        vin_uv_warn_nxt = vin_uv_warn_r;
        st_input_nxt = st_input_r | input_evt_i;
        for (int c = 0; c < 2; c++) begin
            vin_ov_action_nxt[c] = vin_ov_action_r[c];
            turn_on_delay_time_nxt[c] = turn_on_delay_time_r[c];
            turn_on_rise_time_nxt[c] = turn_on_rise_time_r[c];
            ton_limit_nxt[c] = ton_limit_r[c];
            ton_action_nxt[c] = ton_action_r[c];
            turn_off_delay_time_nxt[c] = turn_off_delay_time_r[c];
            turn_off_fall_time_nxt[c] = turn_off_fall_time_r[c];
            st_vout_nxt[c] = st_vout_r[c] | evt_i[c].vout;
            st_vout_nxt[c][`VOUT_TON_MAX] = st_vout_r[c][`VOUT_TON_MAX] | timeout_evt[c];
            st_iout_nxt[c] = st_iout_r[c] | evt_i[c].iout;
            st_temp_nxt[c] = st_temp_r[c] | evt_i[c].temp;
            st_dev_nxt[c] = st_dev_r[c] | evt_i[c].dev;
        end
        rsp_valid_nxt = cmd_i.valid;
        rsp_data_nxt = 16'h0000;
        if (cmd_i.valid) begin
            case (cmd_i.code)
                `CMD_PAGE: begin
                    rsp_data_nxt = {8'h00, page_r};
                    if (wr && cmd_i.wdata[7:1] == 7'h00) begin
                        page_nxt = cmd_i.wdata[7:0];
                    end else if (wr) begin
                        bad_data = 1'b1;
                    end
                end
                `CMD_VIN_OV_LIMIT: begin
                    rsp_data_nxt = vin_ov_limit_r;
                    if (wr) vin_ov_limit_nxt = cmd_i.wdata;
                end
                `CMD_VIN_OV_ACTION: begin
                    rsp_data_nxt = {8'h00, vin_ov_action_r[ch]};
                    if (wr) vin_ov_action_nxt[ch] = cmd_i.wdata[7:0];
                end
                `CMD_VIN_UV_WARN: begin
                    rsp_data_nxt = vin_uv_warn_r;
                    if (wr) vin_uv_warn_nxt = cmd_i.wdata;
                end
                `CMD_TURN_ON_DELAY_TIME: begin
                    rsp_data_nxt = turn_on_delay_time_r[ch];
                    if (wr) turn_on_delay_time_nxt[ch] = cmd_i.wdata;
                end
                `CMD_TURN_ON_RISE_TIME: begin
                    rsp_data_nxt = turn_on_rise_time_r[ch];
                    if (wr) turn_on_rise_time_nxt[ch] = cmd_i.wdata;
                end
                `CMD_TON_LIMIT: begin
                    rsp_data_nxt = ton_limit_r[ch];
                    if (wr) ton_limit_nxt[ch] = cmd_i.wdata;
                end
                `CMD_TON_ACTION: begin
                    rsp_data_nxt = {8'h00, ton_action_r[ch]};
                    if (wr) ton_action_nxt[ch] = cmd_i.wdata[7:0];
                end
                `CMD_TURN_OFF_DELAY_TIME: begin
                    rsp_data_nxt = turn_off_delay_time_r[ch];
                    if (wr) turn_off_delay_time_nxt[ch] = cmd_i.wdata;
                end
                `CMD_TURN_OFF_FALL_TIME: begin
                    rsp_data_nxt = turn_off_fall_time_r[ch];
                    if (wr) turn_off_fall_time_nxt[ch] = cmd_i.wdata;
                end
                `CMD_STAT_BYTE: rsp_data_nxt = {8'h00, sbyte[ch]};
                `CMD_STAT_WORD: rsp_data_nxt = sword[ch];
                `CMD_STAT_VOUT: begin
                    rsp_data_nxt = {8'h00, st_vout_r[ch]};
                    if (wr) st_vout_nxt[ch] = (st_vout_r[ch] & ~clr) | evt_i[ch].vout
                        | {5'h00, timeout_evt[ch], 2'b00};
                end
                `CMD_STAT_IOUT: begin
                    rsp_data_nxt = {8'h00, st_iout_r[ch]};
                    if (wr) st_iout_nxt[ch] = (st_iout_r[ch] & ~clr) | evt_i[ch].iout;
                end
                `CMD_STAT_INPUT: begin
                    rsp_data_nxt = {8'h00, st_input_r};
                    if (wr) st_input_nxt = (st_input_r & ~clr) | input_evt_i;
                end
                `CMD_STAT_TEMP: begin
                    rsp_data_nxt = {8'h00, st_temp_r[ch]};
                    if (wr) st_temp_nxt[ch] = (st_temp_r[ch] & ~clr) | evt_i[ch].temp;
                end
                `CMD_STAT_CML: rsp_data_nxt = {8'h00, st_cml_r};
                `CMD_STAT_DEV: begin
                    rsp_data_nxt = {8'h00, st_dev_r[ch]};
                    if (wr) st_dev_nxt[ch] = (st_dev_r[ch] & ~clr) | evt_i[ch].dev;
                end
                `CMD_MEAS_VIN: rsp_data_nxt = meas_vin_i;
                `CMD_MEAS_VOUT: rsp_data_nxt = meas_i[ch].vout;
                `CMD_MEAS_IOUT: rsp_data_nxt = meas_i[ch].iout;
                `CMD_MEAS_TEXT: rsp_data_nxt = meas_i[ch].text;
                `CMD_MEAS_TINT: rsp_data_nxt = meas_tint_i;
                `CMD_MEAS_FREQ: rsp_data_nxt = meas_i[ch].freq;
                `CMD_REVISION: rsp_data_nxt = {8'h00, `PROTOCOL_REVISION};
                `CMD_MAKER_ID: begin
                    rsp_data_nxt = (cmd_i.index < 4'd3) ?
                        {8'h00, MAKER_STRING[8'(23 - 8 * cmd_i.index) -: 8]} : 16'h0000;
                end
                `CMD_MODEL_ID: begin
                    rsp_data_nxt = (cmd_i.index < 4'd9) ?
                        {8'h00, MODEL_STRING[8'(71 - 8 * cmd_i.index) -: 8]} : 16'h0000;
                end
                default: bad_cmd = 1'b1;
            endcase
            // read-only commands refuse writes
            if (wr && (cmd_i.code == `CMD_STAT_BYTE || cmd_i.code == `CMD_STAT_WORD
                || cmd_i.code == `CMD_MEAS_VIN || cmd_i.code == `CMD_MEAS_VOUT
                || cmd_i.code == `CMD_MEAS_IOUT || cmd_i.code == `CMD_MEAS_TEXT
                || cmd_i.code == `CMD_MEAS_TINT || cmd_i.code == `CMD_MEAS_FREQ
                || cmd_i.code == `CMD_REVISION || cmd_i.code == `CMD_MAKER_ID
                || cmd_i.code == `CMD_MODEL_ID)) begin
                bad_cmd = 1'b1;
            end
        end
        // comms status: clear by write-one, new errors win
        st_cml_nxt = st_cml_r;
        if (wr && cmd_i.code == `CMD_STAT_CML) begin
            st_cml_nxt = st_cml_r & ~clr;
        end
        st_cml_nxt[`CML_BAD_CMD] = st_cml_nxt[`CML_BAD_CMD] | bad_cmd;
        st_cml_nxt[`CML_BAD_DATA] = st_cml_nxt[`CML_BAD_DATA] | bad_data;
    end

    // register all state apart from the enable-pin synchroniser
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            page_r <= `RST_PAGE;
            vin_ov_limit_r <= `RST_VIN_OV_LIMIT;
            vin_uv_warn_r <= `RST_VIN_UV_WARN;
            st_input_r <= 8'h00;
            st_cml_r <= 8'h00;
            rsp_valid_r <= 1'b0;
            rsp_data_r <= 16'h0000;
            pre_r <= 11'h000;
            tick_r <= 1'b0;
            pwr_r <= 2'b00;
            up_r <= 2'b00;
            dn_r <= 2'b00;
            tmo_r <= 2'b00;
            for (int c = 0; c < 2; c++) begin
                vin_ov_action_r[c] <= `RST_VIN_OV_ACTION;
                turn_on_delay_time_r[c] <= `RST_TURN_ON_DELAY_TIME;
                turn_on_rise_time_r[c] <= `RST_TURN_ON_RISE_TIME;
                ton_limit_r[c] <= `RST_TON_LIMIT;
                ton_action_r[c] <= `RST_TON_ACTION;
                turn_off_delay_time_r[c] <= `RST_TURN_OFF_DELAY_TIME;
                turn_off_fall_time_r[c] <= `RST_TURN_OFF_FALL_TIME;
                st_vout_r[c] <= 8'h00;
                st_iout_r[c] <= 8'h00;
                st_temp_r[c] <= 8'h00;
                st_dev_r[c] <= 8'h00;
                seq_r[c] <= SEQ_OFF;
                cnt_r[c] <= 32'h0000_0000;
                tocnt_r[c] <= 32'h0000_0000;
                proven_r[c] <= 1'b0;
            end
        end else begin
            page_r <= page_nxt;
            vin_ov_limit_r <= vin_ov_limit_nxt;
            vin_uv_warn_r <= vin_uv_warn_nxt;
            st_input_r <= st_input_nxt;
            st_cml_r <= st_cml_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            rsp_data_r <= rsp_data_nxt;
            pre_r <= pre_nxt;
            tick_r <= tick_nxt;
            pwr_r <= pwr_nxt;
            up_r <= up_nxt;
            dn_r <= dn_nxt;
            tmo_r <= tmo_nxt;
            for (int c = 0; c < 2; c++) begin
                vin_ov_action_r[c] <= vin_ov_action_nxt[c];
                turn_on_delay_time_r[c] <= turn_on_delay_time_nxt[c];
                turn_on_rise_time_r[c] <= turn_on_rise_time_nxt[c];
                ton_limit_r[c] <= ton_limit_nxt[c];
                ton_action_r[c] <= ton_action_nxt[c];
                turn_off_delay_time_r[c] <= turn_off_delay_time_nxt[c];
                turn_off_fall_time_r[c] <= turn_off_fall_time_nxt[c];
                st_vout_r[c] <= st_vout_nxt[c];
                st_iout_r[c] <= st_iout_nxt[c];
                st_temp_r[c] <= st_temp_nxt[c];
                st_dev_r[c] <= st_dev_nxt[c];
                seq_r[c] <= seq_nxt[c];
                cnt_r[c] <= cnt_nxt[c];
                tocnt_r[c] <= tocnt_nxt[c];
                proven_r[c] <= proven_nxt[c];
            end
        end
    end

    // outputs straight from flip-flops
    assign rsp_valid_o = rsp_valid_r;
    assign rsp_data_o = rsp_data_r;
    assign power_on_o = pwr_r;
    assign ramp_up_o = up_r;
    assign ramp_down_o = dn_r;
    assign ton_timeout_o = tmo_r;
    assign vin_ov_limit_o = vin_ov_limit_r;
    assign vin_uv_warn_o = vin_uv_warn_r;
    assign vin_ov_action_o = {vin_ov_action_r[1], vin_ov_action_r[0]};

endmodule

// ### verif/pmbus_seq_properties.sv
// concurrent checks on the register bank ports
`timescale 1ns/1ns
module pmbus_seq_properties
    import pmbus_seq_pkg::*;
(
    // clock, reset and command port
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire cmd_req_type cmd_i,
    input wire logic rsp_valid_o,
    input wire logic [15:0] rsp_data_o,
    // sequencer and configuration outputs
    input wire logic [1:0] power_on_o,
    input wire logic [1:0] ramp_up_o,
    input wire logic [1:0] ramp_down_o,
    input wire logic [1:0] ton_timeout_o,
    input wire logic [15:0] vin_ov_limit_o,
    input wire logic [15:0] vin_uv_warn_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    // decoded requests
    wire wr_ov = cmd_i.valid && cmd_i.write && cmd_i.code == 8'h55;
    wire wr_uv = cmd_i.valid && cmd_i.write && cmd_i.code == 8'h58;
    wire rd_rev = cmd_i.valid && !cmd_i.write && cmd_i.code == 8'h98;
    a_answer_next: assert property (cmd_i.valid |=> rsp_valid_o)
        else $error("request not answered");
    a_no_stray: assert property (!cmd_i.valid |=> !rsp_valid_o)
        else $error("answer without request");
    a_ov_write: assert property (wr_ov |=> vin_ov_limit_o == $past(cmd_i.wdata))
        else $error("limit word not written");
    a_ov_hold: assert property (!wr_ov |=> $stable(vin_ov_limit_o))
        else $error("limit word moved");
    a_uv_write: assert property (wr_uv |=> vin_uv_warn_o == $past(cmd_i.wdata))
        else $error("warning word not written");
    a_rev_fixed: assert property (rd_rev |=> rsp_data_o == 16'h0022)
        else $error("revision byte wrong");
    a_timeout_pulse: assert property (ton_timeout_o != 2'b00 |=> ton_timeout_o == 2'b00)
        else $error("timeout not a pulse");
    a_ramps_apart: assert property ((ramp_up_o & ramp_down_o) == 2'b00)
        else $error("both ramps at once");
    a_ramp_powered: assert property (((ramp_up_o | ramp_down_o) & ~power_on_o) == 2'b00)
        else $error("ramp while unpowered");
    c_timeout: cover property (ton_timeout_o != 2'b00);
    c_fall: cover property (ramp_down_o != 2'b00);
    c_write: cover property (wr_ov);
endmodule
bind pmbus_seq_status_telemetry_regs pmbus_seq_properties chk (.*);

// ### verif/power_stage_model.sv
// power stage stand-in: output turns good once the rise ramp is over
`timescale 1ns/1ns
module power_stage_model (
    // clock and sequencer view
    input wire logic ref_clk_i,
    input wire logic [1:0] power_on_i,
    input wire logic [1:0] ramp_up_i,
    input wire logic [1:0] stuck_i,
    // output above the undervoltage limit
    output logic [1:0] above_uv_o
);
    initial above_uv_o = 2'b00;
    // a stuck channel never comes up, which provokes the timeout
    always @(posedge ref_clk_i) begin
        above_uv_o <= power_on_i & ~ramp_up_i & ~stuck_i;
    end
endmodule

// ### verif/pmbus_seq_status_telemetry_regs_bench.sv
// self-checking bench for the pmbus register bank
`timescale 1ns/1ns
module pmbus_seq_status_telemetry_regs_bench
    import pmbus_seq_pkg::*;
;
    logic clk = 0, rst_n = 0, run_pin = 0, rsp_valid;
    logic [1:0] op_on = 0, stuck = 0, above_uv, pwr, rup, rdn, tmo;
    logic [15:0] rsp_data, q, ov_act;
    cmd_req_type cmd = '0;
    chan_meas_type [1:0] meas = 128'h0000_0000_0000_0abc_0555_0000_0000_0000;
    int bad_count = 0, n_compared = 0, k;
    logic [7:0] codes [9] = '{8'h55, 8'h56, 8'h58, 8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65};
    logic [15:0] dflt [9] = '{16'hd3e0, 16'h0080, 16'hcb26, 16'h8000, 16'hd200, 16'hd280, 16'h00b8, 16'h8000,
        16'hd200};
    always #25 clk = ~clk;
    pmbus_seq_status_telemetry_regs #(.TICK_CYCLES(4)) DUT (.ref_clk_i(clk), .resetn_i(rst_n), .cmd_i(cmd),
        .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .run_pin_i(run_pin), .operation_on_i(op_on),
        .vout_above_uv_i(above_uv), .meas_vin_i(16'h1234), .meas_tint_i(16'h0777), .meas_i(meas),
        .input_evt_i(8'h00), .evt_i('0), .power_on_o(pwr), .ramp_up_o(rup), .ramp_down_o(rdn),
        .ton_timeout_o(tmo), .vin_ov_limit_o(), .vin_uv_warn_o(), .vin_ov_action_o(ov_act));
    power_stage_model stage (.ref_clk_i(clk), .power_on_i(pwr), .ramp_up_i(rup), .stuck_i(stuck),
        .above_uv_o(above_uv));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one command: raised at a falling edge, answer taken one edge after it is accepted
    task automatic xfer(input logic w, input logic [7:0] c, input logic [3:0] i, input logic [15:0] d);
        @(negedge clk);
        cmd = '{1'b1, w, c, i, d};
        @(negedge clk);
        cmd.valid = 1'b0;
        q = rsp_data;
        check(16'(rsp_valid), 16'h0001);
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // watchdog well beyond the expected run of about twelve hundred cycles
    initial begin
        #(8000 * 50);
        bad_count++;
        conclude();
    end
    initial begin
        repeat (5) @(negedge clk);
        rst_n = 1;
        for (int j = 0; j < 9; j++) begin
            xfer(0, codes[j], 0, 0);
            check(q, dflt[j]);
        end
        xfer(1, 8'h55, 0, 16'h1111);
        xfer(1, 8'h58, 0, 16'h2222);
        xfer(0, 8'h55, 0, 0);
        check(q, 16'h1111);
        xfer(0, 8'h58, 0, 0);
        check(q, 16'h2222);
        // page 1 gets its own action byte, page 0 keeps the default
        xfer(1, 8'h00, 0, 16'h0001);
        xfer(1, 8'h56, 0, 16'h0011);
        xfer(0, 8'h95, 0, 0);
        check(q, 16'h0abc);
        xfer(1, 8'h00, 0, 16'h0000);
        xfer(0, 8'h56, 0, 0);
        check(q, 16'h0080);
        check(ov_act, 16'h1180);
        xfer(0, 8'h88, 0, 0);
        check(q, 16'h1234);
        xfer(0, 8'h8b, 0, 0);
        check(q, 16'h0555);
        xfer(0, 8'h98, 0, 0);
        check(q, 16'h0022);
        xfer(0, 8'h99, 4'h3, 0);
        check(q, 16'h0000);
        // write to read-only word and bad page are both flagged, then cleared
        xfer(1, 8'h88, 0, 16'h5555);
        xfer(1, 8'h00, 0, 16'h0002);
        xfer(0, 8'h7e, 0, 0);
        check(q & 16'h00c0, 16'h00c0);
        xfer(0, 8'h78, 0, 0);
        check(q & 16'h0042, 16'h0042);
        xfer(1, 8'h7e, 0, 16'h00c0);
        xfer(0, 8'h7e, 0, 0);
        check(q, 16'h0000);
        // both channels on with default timing, channel 1 never reaches its level
        run_pin = 1;
        stuck = 2'b10;
        op_on = 2'b11;
        for (k = 0; k < 100 && rup[0] !== 1'b1; k++) @(negedge clk);
        check(16'(k < 20), 16'h0001);
        for (k = 0; k < 1000 && rup[0] === 1'b1; k++) @(negedge clk);
        check(16'(k >= 505 && k <= 525), 16'h0001);
        for (k = 0; k < 300 && tmo[1] !== 1'b1; k++) @(negedge clk);
        check(16'(k >= 115 && k <= 145), 16'h0001);
        @(negedge clk);
        check(16'(pwr), 16'h0001);
        xfer(1, 8'h00, 0, 16'h0001);
        xfer(0, 8'h7a, 0, 0);
        check(q & 16'h0004, 16'h0004);
        // channel 0 turns off and falls over the default time
        op_on = 2'b00;
        for (k = 0; k < 100 && rdn[0] !== 1'b1; k++) @(negedge clk);
        check(16'(k < 20), 16'h0001);
        for (k = 0; k < 1000 && rdn[0] === 1'b1; k++) @(negedge clk);
        check(16'(k >= 505 && k <= 525), 16'h0001);
        @(negedge clk);
        check(16'(pwr), 16'h0000);
        conclude();
    end
endmodule
